// *** pkg/sdsl_pkg.sv ***
// constants, types and crc helpers for the sdio card-side slave port
package sdsl_pkg;
   // clock rates in mhz
   localparam int SYS_CLK_MHZ = 100;
   localparam int SYS_CLK_MIN_MHZ = 50;
   localparam int LINK_CLK_MAX_MHZ = 50;
   // command frame geometry
   localparam logic [5:0] FRAME_BITS = 6'h30;
   localparam logic [5:0] CRC_SPAN_BITS = 6'h28;
   localparam logic [5:0] LAST_RX_BIT = 6'h2f;
   localparam logic [1:0] NCR_RISES = 2'h2;
   // command indices
   localparam logic [5:0] CMD_GO_IDLE = 6'h00;
   localparam logic [5:0] CMD_SEND_RCA = 6'h03;
   localparam logic [5:0] CMD_IO_OP_COND = 6'h05;
   localparam logic [5:0] CMD_SELECT = 6'h07;
   localparam logic [5:0] CMD_RW_DIRECT = 6'h34;
   // response fields
   localparam logic [5:0] R4_INDEX = 6'h3f;
   localparam logic [6:0] R4_CRC = 7'h7f;
   localparam logic [31:0] R4_PAYLOAD = 32'h90ff8000;
   localparam logic [15:0] RCA_VALUE = 16'h0001;
   localparam logic [15:0] R1_STATUS = 16'h0000;
   localparam logic [7:0] R5_FLAGS_DIS = 8'h00;
   localparam logic [7:0] R5_FLAGS_CMD = 8'h10;
   // card register locations reached by direct read/write
   localparam logic [7:0] BUS_IF_CTRL_ADDR = 8'h07;
   localparam logic [1:0] BUS_WIDTH_4BIT = 2'h2;
   localparam int MEM_DEPTH = 256;

   typedef enum logic [1:0] {
      PINFN_GPIO = 2'b00,
      PINFN_SD_CMD = 2'b01,
      PINFN_SD_CLK = 2'b10,
      PINFN_SD_DAT = 2'b11
   } sdsl_pinfn_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_RECV = 3'b001,
      ST_CHECK = 3'b010,
      ST_GAP = 3'b011,
      ST_SEND = 3'b100
   } sdsl_state_t;

   // one serial step of the x^7 + x^3 + 1 command crc
   function automatic logic [6:0] crc7_step(input logic [6:0] crc, input logic din);
      logic fb;
      fb = din ^ crc[6];
      return {crc[5:0], 1'b0} ^ (fb ? 7'h09 : 7'h00);
   endfunction

   // crc over the first forty bits of a frame, msb first
   function automatic logic [6:0] crc7_of40(input logic [39:0] data);
      logic [6:0] crc;
      crc = 7'h00;
      for (int i = 39; i >= 0; i--) begin
         crc = crc7_step(crc, data[i]);
      end
      return crc;
   endfunction
endpackage

// *** pkg/sdsl_crc_if.sv ***
// carrier between the slave port and its serial crc checker
`timescale 1ns/10ps
`default_nettype none
interface sdsl_crc_if;
   logic clear;
   logic shift;
   logic din;
   logic [6:0] crc;
   modport gen (input clear, input shift, input din, output crc);
   modport user (output clear, output shift, output din, input crc);
endinterface
`default_nettype wire

// *** hw/sdsl_crc7.sv ***
// serial crc7 accumulator for incoming command frames
`timescale 1ns/10ps
`default_nettype none
module sdsl_crc7
   import sdsl_pkg::*;
(
   input wire logic clk_in,
   input wire logic resetn_in,
   sdsl_crc_if.gen crc_if
);
   logic [6:0] crc;

   // clear wins over shift so a new frame never inherits old bits
   always_ff @(posedge clk_in) begin
      if (!resetn_in || crc_if.clear) begin
         crc <= 7'h00;
      end else if (crc_if.shift) begin
         crc <= crc7_step(crc, crc_if.din);
      end
   end

   assign crc_if.crc = crc;
endmodule // sdsl_crc7
`default_nettype wire

// *** hw/sdsl_top.sv ***
// sdio card-side slave port: command receiver, responder, card memory, pin mux
`timescale 1ns/10ps
`default_nettype none
module sdsl_top
   import sdsl_pkg::*;
(
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic sd_clk_in,
   input wire logic cmd_in,
   output logic cmd_out,
   output logic cmd_oe_n_out,
   input wire logic [3:0] dat_in,
   output logic [3:0] dat_out,
   output logic [3:0] dat_oe_n_out,
   input wire logic [3:0] flash_pin_mask_in,
   output sdsl_pinfn_t pin_four_sel_out,
   output sdsl_pinfn_t pin_five_sel_out,
   output logic [3:0] data_pin_sel_out,
   output logic spi_mode_out,
   output logic bus_4bit_out,
   output logic card_selected_out
);
   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers and link clock edges
   logic [2:0] clk_sy;
   logic [1:0] cmd_sy;
   logic [1:0] cs_sy;
   logic sd_rise;
   logic sd_fall;
   logic cmd_s;

   // first stage feeds only the second; edges are taken from stages two and three
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         clk_sy <= 3'h0;
         cmd_sy <= 2'h3;
         cs_sy <= 2'h3;
      end else begin
         clk_sy <= {clk_sy[1:0], sd_clk_in};
         cmd_sy <= {cmd_sy[0], cmd_in};
         cs_sy <= {cs_sy[0], dat_in[3]};
      end
   end

   assign sd_rise = clk_sy[1] & ~clk_sy[2];
   assign sd_fall = ~clk_sy[1] & clk_sy[2];
   assign cmd_s = cmd_sy[1];

   ////////////////////////////////////////////////////////////////////////////
   // frame state
   sdsl_state_t state;
   logic [5:0] bit_cnt;
   logic [1:0] gap_cnt;
   logic [47:0] rx_sh;
   logic [47:0] tx_sh;
   logic [7:0] mem [MEM_DEPTH];
   logic rca_valid;
   logic spi_mode;
   logic bus_4bit;
   logic card_sel;
   logic line_bit;
   logic line_drive;
   sdsl_crc_if crc_if ();
   sdsl_crc7 u_crc (
      .clk_in(clk_in),
      .resetn_in(resetn_in),
      .crc_if(crc_if)
   );

   // decoded fields of the captured frame
   logic start_seen;
   logic crc_ok;
   logic [5:0] idx;
   logic [31:0] arg;
   logic [7:0] maddr;
   logic is_write;
   logic rd_byte_sel;
   logic has_resp;
   logic [5:0] r_idx;
   logic [31:0] r_pay;

   assign start_seen = (state == ST_IDLE) && sd_rise && !cmd_s;
   assign idx = rx_sh[45:40];
   assign arg = rx_sh[39:8];
   assign maddr = arg[16:9];
   // host direction bit, end bit and crc must all be right
   assign crc_ok = rx_sh[46] && rx_sh[0] && (rx_sh[7:1] == crc_if.crc);
   assign is_write = (state == ST_CHECK) && crc_ok && (idx == CMD_RW_DIRECT) && arg[31];
   assign rd_byte_sel = arg[31] && arg[27];

   // crc covers start bit through argument, cleared between frames
   assign crc_if.clear = (state == ST_IDLE) && !start_seen;
   assign crc_if.shift = sd_rise && (start_seen || (state == ST_RECV && bit_cnt < CRC_SPAN_BITS));
   assign crc_if.din = cmd_s;

   // response selection; cmd0 in sd mode and unknown commands get none
   always_comb begin
      has_resp = 1'b1;
      r_idx = idx;
      r_pay = 32'h00000000;
      unique case (idx)
         CMD_GO_IDLE: has_resp = ~cs_sy[1]; // spi entry answers on miso
         CMD_IO_OP_COND: begin
            r_idx = R4_INDEX;
            r_pay = R4_PAYLOAD;
         end
         CMD_SEND_RCA: r_pay = {RCA_VALUE, R1_STATUS};
         CMD_SELECT: has_resp = (arg[31:16] == RCA_VALUE);
         CMD_RW_DIRECT: begin
            // card info area and card registers come from on-chip memory; a read-after-write echoes the written argument byte
            r_pay = {16'h0000, card_sel ? R5_FLAGS_CMD : R5_FLAGS_DIS,
                     rd_byte_sel ? arg[7:0] : mem[maddr]};
         end
         default: has_resp = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // frame sequencer: receive on rising edges, answer on falling edges
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         state <= ST_IDLE;
         bit_cnt <= 6'h00;
         gap_cnt <= 2'h0;
         rx_sh <= 48'h000000000000;
         tx_sh <= 48'hffffffffffff;
         line_bit <= 1'b1;
         line_drive <= 1'b0;
      end else begin
         unique case (state)
            ST_IDLE: begin
               if (start_seen) begin
                  rx_sh <= {rx_sh[46:0], cmd_s};
                  bit_cnt <= 6'h01;
                  state <= ST_RECV;
               end
            end
            ST_RECV: begin
               if (sd_rise) begin
                  rx_sh <= {rx_sh[46:0], cmd_s};
                  bit_cnt <= bit_cnt + 6'h01;
                  if (bit_cnt == LAST_RX_BIT) begin
                     state <= ST_CHECK;
                  end
               end
            end
            ST_CHECK: begin
               gap_cnt <= 2'h0;
               bit_cnt <= 6'h00;
               // a frame with a bad crc is dropped silently
               if (crc_ok && has_resp) begin
                  tx_sh <= {2'b00, r_idx, r_pay,
                            (r_idx == R4_INDEX) ? R4_CRC : crc7_of40({2'b00, r_idx, r_pay}),
                            1'b1};
                  state <= ST_GAP;
               end else begin
                  state <= ST_IDLE;
               end
            end
            ST_GAP: begin
               // leaves the host its turnaround clocks before the answer
               if (sd_rise) begin
                  gap_cnt <= gap_cnt + 2'h1;
               end
               if (gap_cnt == NCR_RISES && sd_fall) begin
                  state <= ST_SEND;
               end
            end
            ST_SEND: begin
               if (sd_fall) begin
                  if (bit_cnt == FRAME_BITS) begin
                     line_drive <= 1'b0;
                     line_bit <= 1'b1;
                     state <= ST_IDLE;
                  end else begin
                     line_bit <= tx_sh[47];
                     line_drive <= 1'b1;
                     tx_sh <= {tx_sh[46:0], 1'b1};
                     bit_cnt <= bit_cnt + 6'h01;
                  end
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // card state: mode, address, selection and bus width
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         spi_mode <= 1'b0;
         rca_valid <= 1'b0;
         card_sel <= 1'b0;
         bus_4bit <= 1'b0;
      end else if (state == ST_CHECK && crc_ok) begin
         if (idx == CMD_GO_IDLE) begin
            // chip select held low during reset command picks spi mode
            spi_mode <= ~cs_sy[1];
            rca_valid <= 1'b0;
            card_sel <= 1'b0;
            bus_4bit <= 1'b0;
         end
         if (idx == CMD_SEND_RCA) begin
            rca_valid <= 1'b1;
         end
         if (idx == CMD_SELECT) begin
            card_sel <= rca_valid && (arg[31:16] == RCA_VALUE);
         end
         if (is_write && maddr == BUS_IF_CTRL_ADDR) begin
            bus_4bit <= (arg[1:0] == BUS_WIDTH_4BIT);
         end
      end
   end

   // host-programmed card registers; contents are not reset, the host owns them
   always_ff @(posedge clk_in) begin
      if (is_write) begin
         mem[maddr] <= arg[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin mux and line drivers
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         pin_four_sel_out <= PINFN_SD_CMD;
         pin_five_sel_out <= PINFN_SD_CLK;
         data_pin_sel_out <= 4'h0;
      end else begin
         pin_four_sel_out <= PINFN_SD_CMD;
         pin_five_sel_out <= PINFN_SD_CLK;
         // switch once the card is in use, skipping the flash pins of the previous clock's mask
         data_pin_sel_out <= card_sel ? ~flash_pin_mask_in : 4'h0;
      end
   end
   // in spi mode the answer leaves on miso (data 0) instead of cmd
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         cmd_out <= 1'b1;
         cmd_oe_n_out <= 1'b1;
         dat_out <= 4'hf;
         dat_oe_n_out <= 4'hf;
      end else begin
         cmd_out <= line_bit;
         cmd_oe_n_out <= ~(line_drive && !spi_mode);
         dat_out <= {3'h7, line_bit};
         dat_oe_n_out <= {3'h7, ~(line_drive && spi_mode)};
      end
   end

   assign spi_mode_out = spi_mode;
   assign bus_4bit_out = bus_4bit;
   assign card_selected_out = card_sel;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!resetn_in);
   a_sys_clk_rate: assert property (SYS_CLK_MHZ >= SYS_CLK_MIN_MHZ)
      else $error("system clock below link minimum");
   a_link_edge_rate: assert property (sd_rise |=> !sd_rise)
      else $error("link clock edges too close");
   a_pin_mux_fixed: assert property (pin_four_sel_out == PINFN_SD_CMD &&
      pin_five_sel_out == PINFN_SD_CLK) else $error("cmd or clk pin lost its function");
   a_data_auto_sel: assert property (card_sel |=>
      data_pin_sel_out == ~$past(flash_pin_mask_in)) else $error("data pins not switched");
   a_flash_pins_kept: assert property ($changed(flash_pin_mask_in) ||
      (data_pin_sel_out & flash_pin_mask_in) == 4'h0) else $error("flash pin taken");
   a_mem_write_lands: assert property (is_write |=>
      mem[$past(maddr)] == $past(arg[7:0])) else $error("direct write not stored");
   a_read_from_mem: assert property (state == ST_CHECK && crc_ok && !arg[31] &&
      idx == CMD_RW_DIRECT |=> tx_sh[15:8] == $past(mem[maddr])) else $error("read byte wrong");
   a_width_set: assert property (is_write && maddr == BUS_IF_CTRL_ADDR |=>
      bus_4bit == ($past(arg[1:0]) == BUS_WIDTH_4BIT)) else $error("bus width not taken");
   a_bad_crc_drop: assert property (state == ST_CHECK && !crc_ok |=>
      state == ST_IDLE ##1 line_drive == 1'b0) else $error("bad frame answered");
   a_resp_start_bit: assert property ($rose(line_drive) |-> !line_bit ##1
      (!cmd_out || spi_mode)) else $error("response start bit not zero");
   a_resp_end_bit: assert property ($fell(line_drive) |-> $past(line_bit))
      else $error("response end bit not one");
   c_op_cond: cover property (state == ST_CHECK && crc_ok && idx == CMD_IO_OP_COND);
   c_direct_write: cover property (is_write);
   c_selected: cover property ($rose(card_sel));
   c_four_bit: cover property ($rose(bus_4bit));
endmodule // sdsl_top
`default_nettype wire

// *** tb/sdsl_host_model.sv ***
// behavioural sd host that clocks command frames out and collects the responses
`timescale 1ns/10ps
`default_nettype none
module sdsl_host_model (
   output logic sd_clk_out,
   output logic host_cmd_out,
   input wire logic resp_line_in
);
   // the bus clock idles low between frames; a released cmd line reads high
   initial begin
      sd_clk_out = 1'b0;
      host_cmd_out = 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // own x^7 + x^3 + 1 crc, kept apart from the one in the block
   function automatic logic [6:0] crc7(input logic [39:0] d);
      logic [6:0] c;
      logic fb;
      c = 7'h00;
      for (int i = 39; i >= 0; i--) begin
         fb = d[i] ^ c[6];
         c = {c[5:0], 1'b0} ^ (fb ? 7'h09 : 7'h00);
      end
      return c;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // one command at 8 mhz, well inside the 0..50 mhz range
   task automatic send(input logic [5:0] idx, input logic [31:0] arg, input bit bad_crc,
                       output logic [47:0] rsp, output bit got);
      logic [47:0] f;
      f[47:8] = {2'b01, idx, arg}; // start bit, direction bit
      f[7:1] = crc7(f[47:8]) ^ {6'h00, bad_crc}; // bad_crc corrupts the last crc bit
      f[0] = 1'b1; // end bit
      // host changes cmd at the fall, device samples at the rise
      for (int i = 47; i >= 0; i--) begin
         host_cmd_out = f[i];
         #62.5 sd_clk_out = 1'b1;
         #62.5 sd_clk_out = 1'b0;
      end
      host_cmd_out = 1'b1;
      got = 1'b0;
      rsp = 48'h0;
      // look for a start bit within a few clocks; none means no answer
      repeat (8) if (!got) begin
         #62.5 sd_clk_out = 1'b1;
         got = !resp_line_in;
         #62.5 sd_clk_out = 1'b0;
      end
      if (got) repeat (47) begin
         #62.5 sd_clk_out = 1'b1;
         rsp = {rsp[46:0], resp_line_in};
         #62.5 sd_clk_out = 1'b0;
      end
      // two spare clocks before the next command, then the clock stands still
      repeat (2) begin
         #62.5 sd_clk_out = 1'b1;
         #62.5 sd_clk_out = 1'b0;
      end
   endtask
endmodule // sdsl_host_model
`default_nettype wire

// *** tb/sdsl_top_tb.sv ***
// self-checking bench for the sdio card-side slave port
`timescale 1ns/10ps
`default_nettype none
module sdsl_top_tb
   import sdsl_pkg::*;
;
   logic clk_in = 1'b0;
   logic resetn = 1'b0;
   logic cs_n = 1'b1;
   logic [3:0] flash_mask = 4'b0101;
   logic sd_clk, host_cmd, cmd_out, cmd_oe_n, spi_mode, bus_4bit, selected;
   logic [3:0] dat_out, dat_oe_n, dat_sel;
   sdsl_pinfn_t pin4, pin5;
   wire logic cmd_line;
   wire logic [2:0] dat_line;
   int failures = 0;
   int checks = 0;
   logic [47:0] rsp;
   bit got;

   // wire levels: pull-ups win where nobody drives
   assign cmd_line = cmd_oe_n ? host_cmd : cmd_out;
   assign dat_line = {dat_oe_n[2] ? 1'b1 : dat_out[2], dat_oe_n[1] ? 1'b1 : dat_out[1],
                      dat_oe_n[0] ? 1'b1 : dat_out[0]};

   // clock
   initial begin
      forever #5 clk_in = ~clk_in;
   end

   sdsl_top i_dut (.clk_in(clk_in), .resetn_in(resetn), .sd_clk_in(sd_clk),
      .cmd_in(cmd_line), .cmd_out(cmd_out), .cmd_oe_n_out(cmd_oe_n),
      .dat_in({cs_n, dat_line}), .dat_out(dat_out), .dat_oe_n_out(dat_oe_n),
      .flash_pin_mask_in(flash_mask), .pin_four_sel_out(pin4), .pin_five_sel_out(pin5),
      .data_pin_sel_out(dat_sel), .spi_mode_out(spi_mode), .bus_4bit_out(bus_4bit),
      .card_selected_out(selected));

   // in spi mode the answer comes back on data line zero instead of cmd
   sdsl_host_model i_host (.sd_clk_out(sd_clk), .host_cmd_out(host_cmd),
      .resp_line_in(cs_n ? cmd_line : dat_line[0]));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict();
      if (failures == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // expected short response: two zero bits, echoed index, payload, crc, end bit
   function automatic logic [47:0] exp_rsp(input logic [5:0] idx, input logic [31:0] pl);
      return {2'b00, idx, pl, i_host.crc7({2'b00, idx, pl}), 1'b1};
   endfunction

   task automatic cmd_expect(input logic [5:0] idx, input logic [31:0] arg, input bit bad,
                             input bit want, input logic [47:0] exp);
      i_host.send(idx, arg, bad, rsp, got);
      check(got, want);
      if (want) check(rsp, exp);
      check(cmd_oe_n, 1'b1);
   endtask

   // direct register access frame: write flag, raw flag, address and data
   function automatic logic [31:0] rw_arg(input bit wr, input bit raw, input logic [7:0] a,
                                          input logic [7:0] d);
      return {wr, 3'h0, raw, 1'b0, 9'h000, a, 1'b0, d};
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset_values();
      check(pin4, PINFN_SD_CMD);
      check(pin5, PINFN_SD_CLK);
      check(dat_sel, 4'h0);
      check({spi_mode, bus_4bit, selected, cmd_oe_n, dat_oe_n}, 8'h1f);
   endtask

   task automatic t_refused();
      cmd_expect(CMD_IO_OP_COND, 32'h0, 1'b1, 1'b0, 48'h0);
      // a matching address is answered before one was handed out, but never selects
      cmd_expect(CMD_SELECT, {RCA_VALUE, 16'h0}, 1'b0, 1'b1,
                 exp_rsp(CMD_SELECT, 32'h0));
      check(selected, 1'b0);
      cmd_expect(CMD_IO_OP_COND, 32'h0, 1'b0, 1'b1,
                 {2'b00, R4_INDEX, R4_PAYLOAD, R4_CRC, 1'b1});
   endtask

   task automatic t_select();
      cmd_expect(CMD_SEND_RCA, 32'h0, 1'b0, 1'b1,
                 exp_rsp(CMD_SEND_RCA, {RCA_VALUE, R1_STATUS}));
      cmd_expect(CMD_SELECT, 32'h00020000, 1'b0, 1'b0, 48'h0);
      check(selected, 1'b0);
      cmd_expect(CMD_SELECT, {RCA_VALUE, 16'h0}, 1'b0, 1'b1, exp_rsp(CMD_SELECT, 32'h0));
      repeat (3) @(negedge clk_in);
      check(selected, 1'b1);
      check(dat_sel, {~flash_mask});
      flash_mask = 4'b1000;
      repeat (3) @(negedge clk_in);
      check(dat_sel, 4'b0111);
   endtask

   task automatic t_direct();
      // write with read-after-write, a plain read back from card memory, then two bus width writes
      cmd_expect(CMD_RW_DIRECT, rw_arg(1'b1, 1'b1, 8'h40, 8'ha5), 1'b0, 1'b1,
                 exp_rsp(CMD_RW_DIRECT, {16'h0, R5_FLAGS_CMD, 8'ha5}));
      cmd_expect(CMD_RW_DIRECT, rw_arg(1'b0, 1'b0, 8'h40, 8'h00), 1'b0, 1'b1,
                 exp_rsp(CMD_RW_DIRECT, {16'h0, R5_FLAGS_CMD, 8'ha5}));
      cmd_expect(CMD_RW_DIRECT, rw_arg(1'b1, 1'b1, BUS_IF_CTRL_ADDR, 8'h02), 1'b0, 1'b1,
                 exp_rsp(CMD_RW_DIRECT, {16'h0, R5_FLAGS_CMD, 8'h02}));
      check(bus_4bit, 1'b1);
      cmd_expect(CMD_RW_DIRECT, rw_arg(1'b1, 1'b0, BUS_IF_CTRL_ADDR, 8'h01), 1'b0, 1'b1,
                 exp_rsp(CMD_RW_DIRECT, {16'h0, R5_FLAGS_CMD, 8'h02}));
      check(bus_4bit, 1'b0);
   endtask

   task automatic t_spi();
      @(negedge clk_in);
      cs_n = 1'b0;
      i_host.send(CMD_GO_IDLE, 32'h0, 1'b0, rsp, got);
      check(got, 1'b1);
      check(rsp, exp_rsp(CMD_GO_IDLE, 32'h0));
      check({spi_mode, selected, dat_sel}, 6'h20);
      check(dat_oe_n, 4'hf);
      @(negedge clk_in);
      cs_n = 1'b1;
      cmd_expect(CMD_GO_IDLE, 32'h0, 1'b0, 1'b0, 48'h0);
      check(spi_mode, 1'b0);
      cmd_expect(CMD_RW_DIRECT, rw_arg(1'b0, 1'b0, 8'h40, 8'h00), 1'b0, 1'b1,
                 exp_rsp(CMD_RW_DIRECT, {16'h0, R5_FLAGS_DIS, 8'ha5}));
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // main sequence: reset held three cycles, then every scenario in turn
   initial begin
      repeat (3) @(negedge clk_in);
      resetn = 1'b1;
      repeat (3) @(negedge clk_in);
      t_reset_values();
      t_refused();
      t_select();
      t_direct();
      t_spi();
      give_verdict();
   end

   // watchdog: the run needs about 150 us, so 600 us means a hang
   initial begin
      #600000;
      failures++;
      give_verdict();
   end
endmodule // sdsl_top_tb
`default_nettype wire
